// >>> hdl/sgpac_pkg.sv
// Purpose: Constants for the configuration, GPIO, monitor and PWM logic
// Assumes: 100 MHz single clock, byte-wide host I/O port accesses
// Notes: Offsets are register indices on the index/data port pairs
`default_nettype none
package sgpac_pkg;
   // Host I/O ports
   localparam logic [15:0] CFG_INDEX_PORT = 16'h002e;
   localparam logic [15:0] CFG_DATA_PORT = 16'h002f;
   localparam logic [15:0] MON_INDEX_PORT = 16'h0295;
   localparam logic [15:0] MON_DATA_PORT = 16'h0296;
   localparam logic [15:0] SIO_SPAN = 16'h0004;
   // Unlock key and exit
   localparam logic [7:0] KEY_B0 = 8'h87;
   localparam logic [7:0] KEY_B1 = 8'h01;
   localparam logic [7:0] KEY_B23 = 8'h55;
   localparam logic [7:0] CFG_CTRL_IDX = 8'h02;
   localparam logic [7:0] CFG_EXIT_VAL = 8'h02;
   localparam logic [7:0] LDN_SEL_IDX = 8'h07;
   localparam logic [7:0] LDN_GPIO = 8'h07;
   localparam logic [7:0] LDN_MON = 8'h04;
   // GPIO logical device
   localparam logic [7:0] PIN_PWM2_IDX = 8'h27;
   localparam logic [7:0] PIN_SET4_IDX = 8'h28;
   localparam logic [7:0] PIN_PWM3_IDX = 8'h29;
   localparam logic [7:0] PIN_EXT2_IDX = 8'h2c;
   localparam logic [7:0] BASE_HI_IDX = 8'h62;
   localparam logic [7:0] BASE_LO_IDX = 8'h63;
   localparam logic [7:0] GPIO_DIR_IDX = 8'hc8;
   localparam logic [7:0] GPIO_PULL_IDX = 8'hb8;
   // Monitor logical device configuration
   localparam logic [7:0] ADC_RATE_IDX = 8'hf4;
   localparam logic [7:0] ADC_RATE_RST = 8'h00;
   localparam int RATE_LSB = 6;
   // Monitor registers
   localparam logic [7:0] PWM_EN_IDX = 8'h13;
   localparam logic [7:0] PWM_CTL_IDX = 8'h14;
   localparam logic [7:0] DUTY2_IDX = 8'h16;
   localparam logic [7:0] DUTY3_IDX = 8'h17;
   localparam logic [7:0] DUTY4_IDX = 8'h88;
   localparam logic [7:0] DUTY5_IDX = 8'h89;
   localparam logic [7:0] ADC_BASE_IDX = 8'h20;
   localparam logic [7:0] TEMP_CPU_IDX = 8'h29;
   localparam logic [7:0] TEMP_AMB_IDX = 8'h2a;
   localparam logic [7:0] SCAN_EN_IDX = 8'h50;
   localparam logic [7:0] THERM_IDX = 8'h51;
   localparam logic [7:0] OFFS_CPU_IDX = 8'h56;
   localparam logic [7:0] OFFS_AMB_IDX = 8'h57;
   localparam logic [7:0] OFFS_LOCK_IDX = 8'h5c;
   localparam logic [7:0] OFFS_UNLOCK = 8'h80;
   localparam logic [7:0] THERM_DIODE = 8'h03;
   localparam logic [7:0] REG_RST = 8'h00;
   localparam logic [7:0] LOCKED_READ = 8'hff;
   // Field positions
   localparam int PWM_FREQ_LSB = 4;
   localparam int PWM2_PIN_BIT = 6;
   localparam int PWM3_PIN_BIT = 1;
   localparam int PWM4_PIN_BIT = 3;
   localparam int PWM5_PIN_BIT = 4;
   localparam int SET4_LSB = 16;
   localparam int GPIO_NUM = 26;
   localparam int ADC_NUM = 8;
   localparam int PWM_NUM = 4;
   // Timing
   localparam int CLK_HZ = 100_000_000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int SCAN_8HZ_PERIOD_NS = 125_000_000;
   localparam int SCAN_BASE_DEF_CYCLES = SCAN_8HZ_PERIOD_NS / CLK_PERIOD_NS;
   localparam int PWM_STEPS = 128;
   localparam int PWM_FREQ_HZ [8] = '{375000, 187500, 93750, 62500,
                                     46875, 23430, 11700, 5870};
   // Key states, Gray coded along the unlock path
   typedef enum logic [2:0] {
      KEY_WAIT = 3'h0,
      KEY_GOT1 = 3'h1,
      KEY_GOT2 = 3'h3,
      KEY_GOT3 = 3'h2,
      CFG_OPEN = 3'h6
   } sgpac_key_e;
   // Clock cycles per PWM step for a frequency code
   function automatic logic [7:0] pwm_step_cycles(input logic [2:0] code);
      return 8'(CLK_HZ / (PWM_FREQ_HZ[code] * PWM_STEPS));
   endfunction : pwm_step_cycles
endpackage : sgpac_pkg
`default_nettype wire

// >>> hdl/sgpac_pwm_if.sv
// Purpose: Settings and output of one PWM channel
// Assumes: Driven by the register logic, read by a channel generator
// Notes: Duty and frequency are sampled by the generator at period start; enable acts at once
`default_nettype none
interface sgpac_pwm_if;
   logic [7:0] duty;
   logic [2:0] freq;
   logic en;
   logic pulse;
   modport ctl (output duty, output freq, output en, input pulse);
   modport gen (input duty, input freq, input en, output pulse);
endinterface : sgpac_pwm_if
`default_nettype wire

// >>> hdl/sgpac_pwm.sv
// Purpose: One PWM channel of 128 steps per period
// Assumes: Duty and frequency may change at any time
// Notes: High fraction is duty/128, values of 128 and up give 100 percent
`default_nettype none
module sgpac_pwm
   import sgpac_pkg::*;
(
   input wire logic i_ref_clk, // System clock
   input wire logic i_srst, // Synchronous reset
   sgpac_pwm_if.gen pw // Channel settings and output
);
   logic [7:0] duty_r;
   logic [2:0] freq_r;
   logic [7:0] pre_r;
   logic [6:0] step_r;
   logic pulse_r;
   logic step_tick;
   logic wrap;

   // Step enable from the prescaler
   assign step_tick = (pre_r == pwm_step_cycles(freq_r) - 8'h01);
   assign wrap = step_tick && (step_r == 7'h7f);

   // Prescaler
   always_ff @(posedge i_ref_clk) begin
      if (i_srst || step_tick) begin
         pre_r <= 8'h00;
      end else begin
         pre_r <= pre_r + 8'h01;
      end
   end

   // Step counter over one period
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         step_r <= 7'h00;
      end else if (step_tick) begin
         step_r <= step_r + 7'h01;
      end
   end

   // New settings only at period start
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         duty_r <= 8'h00;
         freq_r <= 3'h0;
      end else if (wrap) begin
         duty_r <= pw.duty;
         freq_r <= pw.freq;
      end
   end

   // Output compare
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         pulse_r <= 1'b0;
      end else begin
         pulse_r <= pw.en && ({1'b0, step_r} < duty_r);
      end
   end

   assign pw.pulse = pulse_r;
endmodule : sgpac_pwm
`default_nettype wire

// >>> hdl/sgpac_top.sv
// Purpose: Configuration space, GPIO, analog monitor and PWM registers
// Assumes: Host I/O strobes are one cycle wide and synchronous
// Notes: Read data appear one cycle after the read strobe
`default_nettype none
module sgpac_top
   import sgpac_pkg::*;
#(
   parameter int unsigned SCAN_BASE_CYCLES = SCAN_BASE_DEF_CYCLES // 8 Hz scan step
) (
   input wire logic i_ref_clk, // System clock
   input wire logic i_srst, // Synchronous reset
   input wire logic [15:0] i_io_addr, // Host I/O address
   input wire logic i_io_wr, // Host write strobe
   input wire logic i_io_rd, // Host read strobe
   input wire logic [7:0] i_io_wdata, // Host write data
   output logic [7:0] o_io_rdata, // Read data
   output logic o_io_rvalid, // Read data valid pulse
   input wire logic [25:0] i_gpio_in, // Pin levels
   output logic [25:0] o_gpio_out, // Pin output values
   output logic [25:0] o_gpio_oe, // Pin drive enables
   output logic [25:0] o_gpio_pullup, // Pull-up enables
   input wire logic [63:0] i_analog_sample, // Eight converter values
   input wire logic [7:0] i_cpu_temp, // Raw CPU temperature
   input wire logic [7:0] i_amb_temp, // Raw ambient temperature
   output logic o_analog_routed, // Analog inputs on their pins
   output logic o_thermal_diode, // Diode sensing selected
   output logic o_config_open, // Configuration mode active
   output logic o_pulse_out_two, // PWM channel 2 pin
   output logic o_pulse_out_three, // PWM channel 3 pin
   output logic o_pulse_out_four, // PWM channel 4 pin
   output logic o_pulse_out_five // PWM channel 5 pin
);
   sgpac_key_e key_r;
   logic [7:0] cfg_idx_r;
   logic [7:0] ldn_r;
   logic [7:0] pin27_r;
   logic [7:0] pin28_r;
   logic [7:0] pin29_r;
   logic [7:0] pin2c_r;
   logic [7:0] base_hi_r;
   logic [7:0] base_lo_r;
   logic [31:0] dir_r;
   logic [31:0] pull_r;
   logic [31:0] gpo_r;
   logic [7:0] rate_r;
   logic [7:0] mon_idx_r;
   logic [7:0] pwm_en_r;
   logic [7:0] pwm_ctl_r;
   logic [7:0] duty_r [PWM_NUM];
   logic [7:0] scan_en_r;
   logic [7:0] therm_r;
   logic [7:0] offs_cpu_r;
   logic [7:0] offs_amb_r;
   logic [7:0] lock_r;
   logic [7:0] adc_r [ADC_NUM];
   logic [7:0] tcpu_r;
   logic [7:0] tamb_r;
   logic [23:0] base_cnt_r;
   logic [2:0] sub_r;
   logic [7:0] rdata_r;
   logic rvalid_r;
   logic cfg_open;
   logic wr_cidx;
   logic wr_cdat;
   logic wr_gpio;
   logic wr_mdev;
   logic wr_mon;
   logic wr_sio;
   logic sio_hit;
   logic [15:0] sio_base;
   logic [15:0] sio_off;
   logic base_tick;
   logic scan_tick;
   logic [2:0] rate_mask;
   logic [25:0] is_gpio;
   logic [7:0] rd_nxt;
   logic rd_hit;
   logic [3:0] pwm_pulse;
   logic [3:0] pwm_en;
   sgpac_pwm_if pwm_bus [PWM_NUM] ();
   // Access decode
   assign cfg_open = (key_r == CFG_OPEN);
   assign wr_cidx = i_io_wr && (i_io_addr == CFG_INDEX_PORT);
   assign wr_cdat = i_io_wr && (i_io_addr == CFG_DATA_PORT) && cfg_open;
   assign wr_gpio = wr_cdat && (ldn_r == LDN_GPIO);
   assign wr_mdev = wr_cdat && (ldn_r == LDN_MON);
   assign wr_mon = i_io_wr && (i_io_addr == MON_DATA_PORT);
   assign sio_base = {base_hi_r, base_lo_r};
   assign sio_off = i_io_addr - sio_base;
   assign sio_hit = (sio_base != 16'h0000) && (sio_off < SIO_SPAN);
   assign wr_sio = i_io_wr && sio_hit;
   // Unlock key and exit sequence
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         key_r <= KEY_WAIT;
      end else if (wr_cidx && !cfg_open) begin
         unique case (key_r)
            KEY_WAIT: key_r <= (i_io_wdata == KEY_B0) ? KEY_GOT1 : KEY_WAIT;
            KEY_GOT1: key_r <= (i_io_wdata == KEY_B1) ? KEY_GOT2 :
                               (i_io_wdata == KEY_B0) ? KEY_GOT1 : KEY_WAIT;
            KEY_GOT2: key_r <= (i_io_wdata == KEY_B23) ? KEY_GOT3 :
                               (i_io_wdata == KEY_B0) ? KEY_GOT1 : KEY_WAIT;
            KEY_GOT3: key_r <= (i_io_wdata == KEY_B23) ? CFG_OPEN :
                               (i_io_wdata == KEY_B0) ? KEY_GOT1 : KEY_WAIT;
            default: key_r <= KEY_WAIT;
         endcase
      end else if (wr_cdat && (cfg_idx_r == CFG_CTRL_IDX) && (i_io_wdata == CFG_EXIT_VAL)) begin
         key_r <= KEY_WAIT;
      end
   end
   // Configuration index and logical device
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         cfg_idx_r <= REG_RST;
         ldn_r <= REG_RST;
      end else begin
         if (wr_cidx && cfg_open) begin
            cfg_idx_r <= i_io_wdata;
         end
         if (wr_cdat && (cfg_idx_r == LDN_SEL_IDX)) begin
            ldn_r <= i_io_wdata;
         end
      end
   end
   // GPIO logical device registers
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         pin27_r <= REG_RST;
         pin28_r <= REG_RST;
         pin29_r <= REG_RST;
         pin2c_r <= REG_RST;
         base_hi_r <= REG_RST;
         base_lo_r <= REG_RST;
         dir_r <= 32'h0000_0000;
         pull_r <= 32'h0000_0000;
      end else if (wr_gpio) begin
         if (cfg_idx_r == PIN_PWM2_IDX) pin27_r <= i_io_wdata;
         if (cfg_idx_r == PIN_SET4_IDX) pin28_r <= i_io_wdata;
         if (cfg_idx_r == PIN_PWM3_IDX) pin29_r <= i_io_wdata;
         if (cfg_idx_r == PIN_EXT2_IDX) pin2c_r <= i_io_wdata;
         if (cfg_idx_r == BASE_HI_IDX) base_hi_r <= i_io_wdata;
         if (cfg_idx_r == BASE_LO_IDX) base_lo_r <= i_io_wdata;
         if (cfg_idx_r[7:2] == GPIO_DIR_IDX[7:2]) begin
            dir_r[cfg_idx_r[1:0]*8 +: 8] <= i_io_wdata;
         end
         if (cfg_idx_r[7:2] == GPIO_PULL_IDX[7:2]) begin
            pull_r[cfg_idx_r[1:0]*8 +: 8] <= i_io_wdata;
         end
      end
   end
   // Monitor logical device rate register
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         rate_r <= ADC_RATE_RST;
      end else if (wr_mdev && (cfg_idx_r == ADC_RATE_IDX)) begin
         rate_r <= i_io_wdata;
      end
   end
   // Simple-I/O output values
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         gpo_r <= 32'h0000_0000;
      end else if (wr_sio) begin
         gpo_r[sio_off[1:0]*8 +: 8] <= i_io_wdata;
      end
   end
   // Monitor index and writable monitor registers
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         mon_idx_r <= REG_RST;
         pwm_en_r <= REG_RST;
         pwm_ctl_r <= REG_RST;
         scan_en_r <= REG_RST;
         therm_r <= REG_RST;
         lock_r <= REG_RST;
         offs_cpu_r <= REG_RST;
         offs_amb_r <= REG_RST;
      end else begin
         if (i_io_wr && (i_io_addr == MON_INDEX_PORT)) mon_idx_r <= i_io_wdata;
         if (wr_mon) begin
            if (mon_idx_r == PWM_EN_IDX) pwm_en_r <= i_io_wdata;
            if (mon_idx_r == PWM_CTL_IDX) pwm_ctl_r <= i_io_wdata;
            if (mon_idx_r == SCAN_EN_IDX) scan_en_r <= i_io_wdata;
            if (mon_idx_r == THERM_IDX) therm_r <= i_io_wdata;
            if (mon_idx_r == OFFS_LOCK_IDX) lock_r <= i_io_wdata;
            if ((mon_idx_r == OFFS_CPU_IDX) && (lock_r == OFFS_UNLOCK)) begin
               offs_cpu_r <= i_io_wdata;
            end
            if ((mon_idx_r == OFFS_AMB_IDX) && (lock_r == OFFS_UNLOCK)) begin
               offs_amb_r <= i_io_wdata;
            end
         end
      end
   end
   // Duty registers, one per channel
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         for (int k = 0; k < PWM_NUM; k++) duty_r[k] <= REG_RST;
      end else if (wr_mon) begin
         if (mon_idx_r == DUTY2_IDX) duty_r[0] <= i_io_wdata;
         if (mon_idx_r == DUTY3_IDX) duty_r[1] <= i_io_wdata;
         if (mon_idx_r == DUTY4_IDX) duty_r[2] <= i_io_wdata;
         if (mon_idx_r == DUTY5_IDX) duty_r[3] <= i_io_wdata;
      end
   end
   // Scan timing: 8 Hz base ticks, divided down by the rate code
   assign base_tick = (base_cnt_r == 24'(SCAN_BASE_CYCLES - 1));
   assign rate_mask = 3'h7 >> rate_r[RATE_LSB +: 2];
   assign scan_tick = base_tick && ((sub_r & rate_mask) == rate_mask);
   always_ff @(posedge i_ref_clk) begin
      if (i_srst || base_tick) begin
         base_cnt_r <= 24'h00_0000;
      end else begin
         base_cnt_r <= base_cnt_r + 24'h00_0001;
      end
   end
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         sub_r <= 3'h0;
      end else if (base_tick) begin
         sub_r <= sub_r + 3'h1;
      end
   end
   // Conversion results, captured only for enabled channels
   for (genvar g = 0; g < ADC_NUM; g++) begin : g_adc
      always_ff @(posedge i_ref_clk) begin
         if (i_srst) begin
            adc_r[g] <= REG_RST;
         end else if (scan_tick && scan_en_r[g]) begin
            adc_r[g] <= i_analog_sample[g*8 +: 8];
         end
      end
   end
   // Temperatures with offset adjust, signed bytes
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         tcpu_r <= REG_RST;
         tamb_r <= REG_RST;
      end else if (scan_tick) begin
         tcpu_r <= i_cpu_temp + offs_cpu_r;
         tamb_r <= i_amb_temp + offs_amb_r;
      end
   end
   // Read data selection
   always_comb begin
      rd_nxt = REG_RST;
      rd_hit = 1'b0;
      if (i_io_addr == CFG_INDEX_PORT) begin
         rd_hit = 1'b1;
         rd_nxt = cfg_open ? cfg_idx_r : LOCKED_READ;
      end else if (i_io_addr == CFG_DATA_PORT) begin
         rd_hit = 1'b1;
         rd_nxt = cfg_open ? REG_RST : LOCKED_READ;
         if (cfg_open && (cfg_idx_r == LDN_SEL_IDX)) begin
            rd_nxt = ldn_r;
         end else if (cfg_open && (ldn_r == LDN_GPIO)) begin
            if (cfg_idx_r == PIN_PWM2_IDX) rd_nxt = pin27_r;
            if (cfg_idx_r == PIN_SET4_IDX) rd_nxt = pin28_r;
            if (cfg_idx_r == PIN_PWM3_IDX) rd_nxt = pin29_r;
            if (cfg_idx_r == PIN_EXT2_IDX) rd_nxt = pin2c_r;
            if (cfg_idx_r == BASE_HI_IDX) rd_nxt = base_hi_r;
            if (cfg_idx_r == BASE_LO_IDX) rd_nxt = base_lo_r;
            if (cfg_idx_r[7:2] == GPIO_DIR_IDX[7:2]) rd_nxt = dir_r[cfg_idx_r[1:0]*8 +: 8];
            if (cfg_idx_r[7:2] == GPIO_PULL_IDX[7:2]) rd_nxt = pull_r[cfg_idx_r[1:0]*8 +: 8];
         end else if (cfg_open && (ldn_r == LDN_MON) && (cfg_idx_r == ADC_RATE_IDX)) begin
            rd_nxt = rate_r;
         end
      end else if (i_io_addr == MON_INDEX_PORT) begin
         rd_hit = 1'b1;
         rd_nxt = mon_idx_r;
      end else if (i_io_addr == MON_DATA_PORT) begin
         rd_hit = 1'b1;
         if (mon_idx_r[7:3] == ADC_BASE_IDX[7:3]) rd_nxt = adc_r[mon_idx_r[2:0]];
         if (mon_idx_r == TEMP_CPU_IDX) rd_nxt = tcpu_r;
         if (mon_idx_r == TEMP_AMB_IDX) rd_nxt = tamb_r;
         if (mon_idx_r == PWM_EN_IDX) rd_nxt = pwm_en_r;
         if (mon_idx_r == PWM_CTL_IDX) rd_nxt = pwm_ctl_r;
         if (mon_idx_r == DUTY2_IDX) rd_nxt = duty_r[0];
         if (mon_idx_r == DUTY3_IDX) rd_nxt = duty_r[1];
         if (mon_idx_r == DUTY4_IDX) rd_nxt = duty_r[2];
         if (mon_idx_r == DUTY5_IDX) rd_nxt = duty_r[3];
         if (mon_idx_r == SCAN_EN_IDX) rd_nxt = scan_en_r;
         if (mon_idx_r == THERM_IDX) rd_nxt = therm_r;
         if (mon_idx_r == OFFS_CPU_IDX) rd_nxt = offs_cpu_r;
         if (mon_idx_r == OFFS_AMB_IDX) rd_nxt = offs_amb_r;
         if (mon_idx_r == OFFS_LOCK_IDX) rd_nxt = lock_r;
      end else if (sio_hit) begin
         rd_hit = 1'b1;
         rd_nxt = 8'({6'h00, i_gpio_in} >> (sio_off[1:0]*8));
      end
   end
   // Registered read answer
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         rdata_r <= REG_RST;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= i_io_rd && rd_hit;
         if (i_io_rd && rd_hit) rdata_r <= rd_nxt;
      end
   end
   // Pin function per GPIO pin
   for (genvar p = 0; p < GPIO_NUM; p++) begin : g_pin
      if (p >= SET4_LSB && p < SET4_LSB + 8) begin : g_set4
         assign is_gpio[p] = pin28_r[p - SET4_LSB];
      end else if (p >= SET4_LSB + 8) begin : g_pwm_pin
         assign is_gpio[p] = !pin2c_r[PWM4_PIN_BIT + p - SET4_LSB - 8];
      end else begin : g_plain
         assign is_gpio[p] = 1'b1;
      end
   end
   // PWM channel enables and generators
   assign pwm_en[1:0] = pwm_en_r[2:1] & pwm_ctl_r[2:1];
   assign pwm_en[3:2] = {pin2c_r[PWM5_PIN_BIT], pin2c_r[PWM4_PIN_BIT]};
   for (genvar c = 0; c < PWM_NUM; c++) begin : g_pwm
      assign pwm_bus[c].duty = duty_r[c];
      assign pwm_bus[c].freq = pwm_ctl_r[PWM_FREQ_LSB +: 3];
      assign pwm_bus[c].en = pwm_en[c];
      assign pwm_pulse[c] = pwm_bus[c].pulse;
      sgpac_pwm u_pwm (
         .i_ref_clk(i_ref_clk),
         .i_srst(i_srst),
         .pw(pwm_bus[c])
      );
   end
   // Outputs
   assign o_io_rdata = rdata_r;
   assign o_io_rvalid = rvalid_r;
   assign o_gpio_out = gpo_r[GPIO_NUM-1:0];
   assign o_gpio_oe = dir_r[GPIO_NUM-1:0] & is_gpio;
   assign o_gpio_pullup = pull_r[GPIO_NUM-1:0];
   assign o_analog_routed = (pin2c_r[1:0] == 2'b00);
   assign o_thermal_diode = (therm_r == THERM_DIODE);
   assign o_config_open = cfg_open;
   assign o_pulse_out_two = pwm_pulse[0] && !pin27_r[PWM2_PIN_BIT];
   assign o_pulse_out_three = pwm_pulse[1] && !pin29_r[PWM3_PIN_BIT];
   assign o_pulse_out_four = pwm_pulse[2];
   assign o_pulse_out_five = pwm_pulse[3];
endmodule : sgpac_top
`default_nettype wire

// >>> tb/sgpac_top_monitor.sv
// Purpose: Port checks for the configuration and monitor block
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to the top module
`default_nettype none
module sgpac_top_monitor
   import sgpac_pkg::*;
(
   input wire logic i_ref_clk, // Clock
   input wire logic i_srst, // Reset
   input wire logic [15:0] i_io_addr, // Address
   input wire logic i_io_wr, // Write
   input wire logic i_io_rd, // Read
   input wire logic [7:0] i_io_wdata, // Write data
   input wire logic [7:0] o_io_rdata, // Read data
   input wire logic o_io_rvalid, // Read valid
   input wire logic [25:0] o_gpio_oe, // Pin enables
   input wire logic o_analog_routed, // Analog routed
   input wire logic o_thermal_diode, // Diode mode
   input wire logic o_config_open // Config open
);
   default clocking @(posedge i_ref_clk);
   endclocking
   default disable iff (i_srst);
   // Decoded host writes
   wire logic key_wr = i_io_wr && i_io_addr == CFG_INDEX_PORT && i_io_wdata == KEY_B23;
   wire logic cfg_wr = i_io_wr && i_io_addr == CFG_DATA_PORT;
   wire logic mon_wr = i_io_wr && i_io_addr == MON_DATA_PORT;
   a_cfg_rd: assert property (p_cfg_rd) else $error("config read unanswered");
   property p_cfg_rd; i_io_rd && i_io_addr == CFG_INDEX_PORT |=> o_io_rvalid; endproperty
   a_mon_rd: assert property (p_mon_rd) else $error("monitor read unanswered");
   property p_mon_rd; i_io_rd && i_io_addr == MON_DATA_PORT |=> o_io_rvalid; endproperty
   a_rv_src: assert property (p_rv_src) else $error("read valid without read");
   property p_rv_src; o_io_rvalid |-> $past(i_io_rd); endproperty
   a_rdata: assert property (p_rdata) else $error("read data moved alone");
   property p_rdata; $changed(o_io_rdata) |-> o_io_rvalid; endproperty
   a_open: assert property (p_open) else $error("config opened early");
   property p_open; $rose(o_config_open) |-> $past(key_wr); endproperty
   a_close: assert property (p_close) else $error("config closed wrongly");
   property p_close; $fell(o_config_open) |-> $past(cfg_wr) && $past(i_io_wdata) == 8'h02;
   endproperty
   a_route: assert property (p_route) else $error("routing moved alone");
   property p_route; !cfg_wr |=> $stable(o_analog_routed); endproperty
   a_oe: assert property (p_oe) else $error("pin enables moved alone");
   property p_oe; !cfg_wr |=> $stable(o_gpio_oe); endproperty
   a_diode: assert property (p_diode) else $error("diode mode moved alone");
   property p_diode; !mon_wr |=> $stable(o_thermal_diode); endproperty
endmodule : sgpac_top_monitor
bind sgpac_top sgpac_top_monitor u_mon (.i_ref_clk, .i_srst, .i_io_addr, .i_io_wr, .i_io_rd,
   .i_io_wdata, .o_io_rdata, .o_io_rvalid, .o_gpio_oe, .o_analog_routed, .o_thermal_diode,
   .o_config_open);
`default_nettype wire

// >>> tb/sgpac_host.sv
// Purpose: Host issuing byte port accesses
// Assumes: Strobes one cycle, driven at falling edge
// Notes: Released lines carry inverted values
`default_nettype none
module sgpac_host
(
   input wire logic i_ref_clk, // Clock
   input wire logic [7:0] i_rdata, // Read data
   input wire logic i_rvalid, // Read valid
   output logic [15:0] o_addr, // Address
   output logic o_wr, // Write strobe
   output logic o_rd, // Read strobe
   output logic [7:0] o_wdata // Write data
);
   timeunit 1ns;
   timeprecision 100ps;
   initial {o_addr, o_wdata, o_wr, o_rd} = '0;
   // Write one byte; key and exit bytes come through here
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge i_ref_clk);
      {o_addr, o_wdata, o_wr} = {a, d, 1'b1};
      @(negedge i_ref_clk);
      {o_addr, o_wdata, o_wr} = {~a, ~d, 1'b0};
   endtask : wr
   // Read one byte, answer taken one cycle after the strobe
   task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
      @(negedge i_ref_clk);
      {o_addr, o_rd} = {a, 1'b1};
      @(negedge i_ref_clk);
      {o_addr, o_rd} = {~a, 1'b0};
      {d, v} = {i_rdata, i_rvalid};
   endtask : rd
endmodule : sgpac_host
`default_nettype wire

// >>> tb/tb_superio_gpio_pwm_adc_config.sv
// Purpose: Self-checking bench for the configuration and monitor block
// Assumes: Scan base shortened to 20 cycles
// Notes: Host model drives all bus traffic
`default_nettype none
module tb_superio_gpio_pwm_adc_config
   import sgpac_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic i_ref_clk = 1'b0;
   logic i_srst = 1'b1;
   logic [15:0] i_io_addr;
   logic i_io_wr, i_io_rd;
   logic [7:0] i_io_wdata, o_io_rdata;
   logic o_io_rvalid, o_analog_routed, o_thermal_diode, o_config_open, o_pulse_out_two;
   logic [25:0] i_gpio_in = 26'h2a5c3e1;
   logic [25:0] o_gpio_out, o_gpio_oe, o_gpio_pullup;
   logic [63:0] i_analog_sample = 64'h8877665544332211;
   logic [7:0] i_cpu_temp = 8'h2b;
   logic [7:0] i_amb_temp = 8'h22;
   int num_errors = 0;
   int total_checks = 0;
   int cyc = 0;
   sgpac_top #(.SCAN_BASE_CYCLES(20)) dut (.i_ref_clk, .i_srst, .i_io_addr, .i_io_wr,
      .i_io_rd, .i_io_wdata, .o_io_rdata, .o_io_rvalid, .i_gpio_in, .o_gpio_out, .o_gpio_oe,
      .o_gpio_pullup, .i_analog_sample, .i_cpu_temp, .i_amb_temp, .o_analog_routed,
      .o_thermal_diode, .o_config_open, .o_pulse_out_two, .o_pulse_out_three(),
      .o_pulse_out_four(), .o_pulse_out_five());
   sgpac_host h (.i_ref_clk, .i_rdata(o_io_rdata), .i_rvalid(o_io_rvalid), .o_addr(i_io_addr),
      .o_wr(i_io_wr), .o_rd(i_io_rd), .o_wdata(i_io_wdata));
   always #5 i_ref_clk = ~i_ref_clk;
   // Cut a hang short
   always @(posedge i_ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic iwr(input bit m, input logic [7:0] i, input logic [7:0] v);
      logic [15:0] p;
      p = m ? MON_INDEX_PORT : CFG_INDEX_PORT;
      h.wr(p, i);
      h.wr(p + 16'h1, v);
   endtask : iwr
   task automatic ird(input bit m, input logic [7:0] i, output logic [7:0] d);
      logic [15:0] p;
      logic v;
      p = m ? MON_INDEX_PORT : CFG_INDEX_PORT;
      h.wr(p, i);
      h.rd(p + 16'h1, d, v);
      chk("rvalid", 1, v);
   endtask : ird
   task automatic unlock(input logic [7:0] last);
      logic [7:0] k [4] = '{KEY_B0, KEY_B1, KEY_B23, last};
      foreach (k[i]) h.wr(CFG_INDEX_PORT, k[i]);
   endtask : unlock
   task automatic t_key();
      logic [7:0] d;
      logic v;
      unlock(8'h00);
      chk("open", 0, o_config_open);
      h.rd(CFG_DATA_PORT, d, v);
      chk("locked", 8'hff, d);
      unlock(KEY_B23);
      chk("open", 1, o_config_open);
      iwr(0, CFG_CTRL_IDX, CFG_EXIT_VAL);
      chk("open", 0, o_config_open);
   endtask : t_key
   task automatic t_gpio();
      logic [7:0] d;
      logic v;
      unlock(KEY_B23);
      iwr(0, LDN_SEL_IDX, LDN_GPIO);
      iwr(0, PIN_SET4_IDX, 8'h03);
      iwr(0, GPIO_DIR_IDX + 8'h2, 8'h0f);
      iwr(0, GPIO_DIR_IDX + 8'h3, 8'h03);
      iwr(0, GPIO_PULL_IDX, 8'h81);
      iwr(0, PIN_EXT2_IDX, 8'h1b);
      iwr(0, BASE_HI_IDX, 8'h12);
      iwr(0, BASE_LO_IDX, 8'h20);
      chk("oe", 10'h003, o_gpio_oe[25:16]);
      chk("pull", 8'h81, o_gpio_pullup[7:0]);
      chk("routed", 0, o_analog_routed);
      ird(0, PIN_EXT2_IDX, d);
      iwr(0, PIN_EXT2_IDX, d & 8'hfc);
      ird(0, PIN_EXT2_IDX, d);
      chk("ext2", 8'h18, d);
      chk("routed", 1, o_analog_routed);
      iwr(0, CFG_CTRL_IDX, CFG_EXIT_VAL);
      h.wr(16'h1222, 8'h55);
      chk("gout", 8'h55, o_gpio_out[23:16]);
      h.rd(16'h1222, d, v);
      chk("gin", 8'ha5, d);
   endtask : t_gpio
   task automatic t_mon();
      logic [7:0] d;
      unlock(KEY_B23);
      iwr(0, LDN_SEL_IDX, LDN_MON);
      iwr(0, ADC_RATE_IDX, 8'hc0);
      iwr(0, CFG_CTRL_IDX, CFG_EXIT_VAL);
      iwr(1, SCAN_EN_IDX, 8'h81);
      iwr(1, OFFS_CPU_IDX, 8'h10);
      iwr(1, OFFS_LOCK_IDX, OFFS_UNLOCK);
      iwr(1, OFFS_AMB_IDX, 8'h3c);
      iwr(1, OFFS_LOCK_IDX, 8'h00);
      iwr(1, THERM_IDX, THERM_DIODE);
      iwr(1, ADC_BASE_IDX, 8'h5a);
      chk("diode", 1, o_thermal_diode);
      repeat (60) @(negedge i_ref_clk);
      ird(1, ADC_BASE_IDX, d);
      chk("adc0", 8'h11, d);
      ird(1, ADC_BASE_IDX + 8'h7, d);
      chk("adc7", 8'h88, d);
      ird(1, ADC_BASE_IDX + 8'h1, d);
      chk("adc1", 8'h00, d);
      ird(1, TEMP_CPU_IDX, d);
      chk("tcpu", 8'h2b, d);
      ird(1, TEMP_AMB_IDX, d);
      chk("tamb", 8'h5e, d);
   endtask : t_mon
   task automatic meas(output int hi, output int ris);
      logic p;
      p = o_pulse_out_two;
      hi = 0;
      ris = 0;
      repeat (1024) begin
         @(negedge i_ref_clk);
         hi += int'(o_pulse_out_two);
         ris += int'(o_pulse_out_two && !p);
         p = o_pulse_out_two;
      end
   endtask : meas
   task automatic t_pwm();
      int hi;
      int ris;
      iwr(1, PWM_EN_IDX, 8'h07);
      iwr(1, PWM_CTL_IDX, 8'h07);
      iwr(1, DUTY2_IDX, 8'h40);
      repeat (600) @(negedge i_ref_clk);
      meas(hi, ris);
      chk("high", 512, hi);
      chk("rises", 4, ris);
      iwr(1, PWM_CTL_IDX, 8'h17);
      repeat (600) @(negedge i_ref_clk);
      meas(hi, ris);
      chk("rises", 2, ris);
   endtask : t_pwm
   // Main sequence
   initial begin
      repeat (3) @(posedge i_ref_clk);
      @(negedge i_ref_clk);
      i_srst = 1'b0;
      t_key();
      t_gpio();
      t_mon();
      t_pwm();
      end_sim();
   end
endmodule : tb_superio_gpio_pwm_adc_config
`default_nettype wire
